//--- core/cdrc_top.sv
// Clock divide, reset and ring oscillator control for the microcontroller core.
`timescale 1ns/100ps
// Contract
// - Device stays in reset while pin is high, then starts from address zero.
// - Pin reset in Stop restarts oscillator, zeroes PC, waits 65,536 clocks.
// - Power-fail, watchdog or system reset drives reset pin for its duration.
// - Enabled detector resets below 30 kHz and holds reset on the ring.
// - Fail-detect enable set by software, cleared by power-fail reset or software.
// - Oscillator-fail reset sets flag; only software or power-on reset clears it.
// - No oscillator-fail reset while crystal is stopped by Stop mode.
// - Divide field 11b selects 1024 oscillator cycles per machine cycle.
// - Every reset returns divide field to 10b, divide by one.
// - Switchback only when enabled; in 1024 mode events force divide by one.
// - Low on irq 0,1,3,5 or high on 2,4, enabled and allowed, switch back.
// - Enabled receive falling edge or any transmit activity also switches back.
// - Write of 1024 mode while a serial port is active selects divide by one instead.
// - Without switchback or outside 1024 mode, events leave divider alone.
// - Timers tick every 12 oscillators, or every 12 machine cycles in 1024 mode.
// - Serial mode-2 divides by 64 or 32, scaled by 1024 in 1024 mode.
// - Multiplier and divide code decode to 0.25, 0.5, 1, 1024; x01 reserved. Here 0.25 and 0.5 run at one tick per clock, as for 1.
// - Ring clocks system after Stop exit until crystal start-up, then switches off.
// - Without ring select, execution waits 65,536 crystal periods after Stop.
// - Ring status shows clock source; divide field locked at 10b meanwhile.
module cdrc_top #(
  parameter int XTAL_WAIT = cdrc_pkg::XTAL_WAIT_CYC,
  parameter int FAIL_GAP = cdrc_pkg::OSC_FAIL_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_out,
  input wire logic power_fail_rst_in,
  input wire logic power_on_rst_in,
  input wire logic watchdog_rst_in,
  input wire logic system_rst_in,
  input wire logic xtal_edge_in,
  input wire logic stop_req_in,
  input wire logic stop_wake_in,
  input wire logic pmr_wr_in,
  input wire logic [1:0] clock_divide_wr_in,
  input wire logic switchback_enable_wr_in,
  input wire logic multiplier_select_in,
  input wire logic power_control_reg_wr_in,
  input wire logic osc_fail_detect_enable_wr_in,
  input wire logic osc_fail_flag_wr_in,
  input wire logic extended_interrupt_flag_reg_wr_in,
  input wire logic ring_select_wr_in,
  input wire logic [5:0] irq_level_in,
  input wire logic [5:0] irq_allowed_in,
  input wire logic [1:0] rx_enable_in,
  input wire logic [1:0] rx_pin_in,
  input wire logic [1:0] tx_active_in,
  input wire logic [1:0] rx_active_in,
  input wire logic [1:0] timer_clock_select_in,
  input wire logic serial_double_rate_in,
  output logic [1:0] clock_divide_out,
  output logic switchback_enable_out,
  output logic osc_fail_detect_enable_out,
  output logic osc_fail_flag_out,
  output logic ring_select_out,
  output logic ring_mode_status_out,
  output logic ring_osc_on_out,
  output logic core_rst_out,
  output logic [15:0] pc_load_out,
  output logic [2:0] mc_ratio_out,
  output logic mc_tick_out,
  output logic timer_tick_out,
  output logic serial_tick_out,
  output logic baud_tick_out
);
  import cdrc_pkg::*;

  // The warm-up and gap counters are sized for these limits.
  if (XTAL_WAIT < 1 || XTAL_WAIT > 65536 || FAIL_GAP < 2 || FAIL_GAP > 65535) begin : g_param_check
    $error("cdrc_top: parameter out of range");
  end

  // Reports whether a 0..period-1 counter is at its last count and wraps next.
  // A count left above a new, shorter period wraps at once instead of running on for ages.
  function automatic logic wrap(input logic [26:0] cnt, input int period);
    wrap = (cnt >= 27'(period - 1));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources and oscillator-fail detection.
  cdrc_state_t state_q;
  logic [15:0] gap_q;
  logic [16:0] warm_q;
  logic rst_pin_q;
  logic osc_fail_q;
  logic ext_stop_rst_q;
  logic int_rst;
  logic any_rst;

  assign int_rst = power_fail_rst_in | watchdog_rst_in | system_rst_in | power_on_rst_in;
  assign any_rst = int_rst | rst_pin_in | osc_fail_q | ~rst_n_in;

  // Pin level taken as synchronous; one register stage holds core reset one clock past a glitch.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rst_pin_q <= 1'b0;
    end else begin
      rst_pin_q <= rst_pin_in;
    end
  end

  // Crystal edge gap counter; held at zero in Stop because the crystal is off on purpose.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      gap_q <= 16'h0000;
      osc_fail_q <= 1'b0;
    end else if (xtal_edge_in || state_q == CDRC_STOP || !osc_fail_detect_enable_out) begin
      gap_q <= 16'h0000;
      osc_fail_q <= 1'b0;
    end else if (gap_q >= 16'(FAIL_GAP)) begin
      osc_fail_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop, warm-up and ring oscillator sequencing.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_q <= CDRC_RUN;
      warm_q <= 17'h0_0000;
      ext_stop_rst_q <= 1'b0;
    end else begin
      case (state_q)
        CDRC_RUN: begin
          if (stop_req_in && !any_rst) begin
            state_q <= CDRC_STOP;
          end
        end
        CDRC_STOP: begin
          warm_q <= 17'h0_0000;
          if (rst_pin_in) begin
            ext_stop_rst_q <= 1'b1;
            state_q <= CDRC_WARM;
          end else if (stop_wake_in) begin
            state_q <= CDRC_WARM;
          end
        end
        CDRC_WARM: begin
          // Crystal periods are counted, not system clocks, when a crystal edge is seen.
          if (xtal_edge_in) begin
            warm_q <= warm_q + 17'h0_0001;
          end
          if (warm_q >= 17'(XTAL_WAIT)) begin
            state_q <= CDRC_RUN;
            ext_stop_rst_q <= 1'b0;
          end
        end
        default: begin
          state_q <= CDRC_RUN;
        end
      endcase
    end
  end

  // Core reset, program counter load, ring status and the pin driver.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      core_rst_out <= 1'b1;
      pc_load_out <= RESET_VECTOR;
      ring_mode_status_out <= 1'b0;
      ring_osc_on_out <= 1'b0;
      rst_pin_out <= 1'b0;
      rst_pin_oe_out <= 1'b0;
    end else begin
      core_rst_out <= any_rst | rst_pin_q | ext_stop_rst_q |
        (state_q == CDRC_WARM && !ring_select_out);
      pc_load_out <= RESET_VECTOR;
      ring_mode_status_out <= (state_q == CDRC_WARM && ring_select_out && !ext_stop_rst_q);
      ring_osc_on_out <= osc_fail_q | (state_q == CDRC_WARM && ring_select_out);
      rst_pin_out <= power_fail_rst_in | watchdog_rst_in | system_rst_in;
      rst_pin_oe_out <= power_fail_rst_in | watchdog_rst_in | system_rst_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits held here on behalf of software.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || power_fail_rst_in) begin
      osc_fail_detect_enable_out <= 1'b0;
    end else if (power_control_reg_wr_in) begin
      osc_fail_detect_enable_out <= osc_fail_detect_enable_wr_in;
    end
  end

  // Set wins over a same-cycle software clear.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || power_on_rst_in) begin
      osc_fail_flag_out <= 1'b0;
    end else if (osc_fail_q) begin
      osc_fail_flag_out <= 1'b1;
    end else if (power_control_reg_wr_in) begin
      osc_fail_flag_out <= osc_fail_flag_wr_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ring_select_out <= 1'b0;
      switchback_enable_out <= 1'b0;
    end else begin
      if (extended_interrupt_flag_reg_wr_in) begin
        ring_select_out <= ring_select_wr_in;
      end
      if (pmr_wr_in) begin
        switchback_enable_out <= switchback_enable_wr_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock divide field with write filtering and switchback.
  logic [1:0] rx_pin_q;
  logic irq_event;
  logic ser_event;
  logic ser_busy;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rx_pin_q <= 2'h3;
    end else begin
      rx_pin_q <= rx_pin_in;
    end
  end

  assign irq_event = |({irq_level_in[4], ~irq_level_in[5], irq_level_in[2], ~irq_level_in[3],
    ~irq_level_in[1], ~irq_level_in[0]} & {irq_allowed_in[4], irq_allowed_in[5], irq_allowed_in[2],
    irq_allowed_in[3], irq_allowed_in[1], irq_allowed_in[0]});
  assign ser_event = |(rx_enable_in & rx_pin_q & ~rx_pin_in) | (|tx_active_in);
  assign ser_busy = |(tx_active_in | rx_active_in);

  always_ff @(posedge core_clk_in) begin
    if (any_rst || ext_stop_rst_q || ring_mode_status_out) begin
      clock_divide_out <= CDIV_RESET;
    end else if (clock_divide_out == CDIV_PMM && switchback_enable_out && (irq_event || ser_event)) begin
      clock_divide_out <= CDIV_ONE;
    end else if (pmr_wr_in) begin
      if (clock_divide_wr_in == CDIV_PMM && ser_busy) begin
        clock_divide_out <= CDIV_ONE;
      end else if (clock_divide_wr_in != CDIV_RSVD) begin
        clock_divide_out <= clock_divide_wr_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ratio code and tick generation; fast ratios are run at one tick per clock.
  logic [26:0] mc_cnt_q;
  logic [26:0] tmr_cnt_q;
  logic [26:0] ser_cnt_q;
  logic [26:0] baud_cnt_q;
  logic pmm;
  int scale;

  assign pmm = (clock_divide_out == CDIV_PMM);
  assign scale = pmm ? PMM_OSC_PER_MC : 1;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      mc_ratio_out <= {1'b0, CDIV_RESET};
    end else begin
      mc_ratio_out <= {multiplier_select_in, clock_divide_out};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      mc_cnt_q <= 27'h000_0000;
      tmr_cnt_q <= 27'h000_0000;
      ser_cnt_q <= 27'h000_0000;
      baud_cnt_q <= 27'h000_0000;
      mc_tick_out <= 1'b0;
      timer_tick_out <= 1'b0;
      serial_tick_out <= 1'b0;
      baud_tick_out <= 1'b0;
    end else begin
      mc_cnt_q <= wrap(mc_cnt_q, scale) ? 27'h000_0000 : mc_cnt_q + 27'h000_0001;
      mc_tick_out <= wrap(mc_cnt_q, scale);
      if (timer_clock_select_in == TSEL_DIV12) begin
        tmr_cnt_q <= wrap(tmr_cnt_q, TMR_DIV12 * scale) ? 27'h000_0000 : tmr_cnt_q + 27'h000_0001;
        timer_tick_out <= wrap(tmr_cnt_q, TMR_DIV12 * scale);
      end else if (timer_clock_select_in == TSEL_DIV4) begin
        tmr_cnt_q <= wrap(tmr_cnt_q, TMR_DIV4 * scale) ? 27'h000_0000 : tmr_cnt_q + 27'h000_0001;
        timer_tick_out <= wrap(tmr_cnt_q, TMR_DIV4 * scale);
      end else begin
        tmr_cnt_q <= 27'h000_0000;
        timer_tick_out <= wrap(mc_cnt_q, scale);
      end
      ser_cnt_q <= wrap(ser_cnt_q, (serial_double_rate_in ? SER_DIV32 : SER_DIV64) * scale) ?
        27'h000_0000 : ser_cnt_q + 27'h000_0001;
      serial_tick_out <= wrap(ser_cnt_q, (serial_double_rate_in ? SER_DIV32 : SER_DIV64) * scale);
      baud_cnt_q <= wrap(baud_cnt_q, BAUD_DIV2 * scale) ? 27'h000_0000 : baud_cnt_q + 27'h000_0001;
      baud_tick_out <= wrap(baud_cnt_q, BAUD_DIV2 * scale);
    end
  end
endmodule

//--- core/cdrc_pkg.sv
// Package with constants and types for the clock divide and reset control block.
package cdrc_pkg;
  // Clock divide field codes.
  localparam logic [1:0] CDIV_RSVD = 2'h1;
  localparam logic [1:0] CDIV_ONE = 2'h2;
  localparam logic [1:0] CDIV_PMM = 2'h3;
  localparam logic [1:0] CDIV_FAST = 2'h0;
  // Reset value of the divide field.
  localparam logic [1:0] CDIV_RESET = 2'h2;
  // Program counter start address.
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  // Least external reset pin hold, in clock cycles.
  localparam int RST_PIN_MIN_CYC = 3;
  // Crystal start-up wait, in crystal clock cycles.
  localparam int XTAL_WAIT_CYC = 65536;
  // Oscillator cycles per machine cycle in power-management mode.
  localparam int PMM_OSC_PER_MC = 1024;
  // Oscillator-fail threshold, in Hz, and the system clock rate.
  localparam int OSC_FAIL_HZ = 30000;
  localparam int CLK_HZ = 100000000;
  // Longest crystal edge gap before a failure is declared, rounded down.
  localparam int OSC_FAIL_CYC = CLK_HZ / OSC_FAIL_HZ;
  // Prescaler periods for timers and serial clocks in fast modes.
  localparam int TMR_DIV12 = 12;
  localparam int TMR_DIV4 = 4;
  localparam int SER_DIV64 = 64;
  localparam int SER_DIV32 = 32;
  localparam int BAUD_DIV2 = 2;
  // Timer clock select codes.
  localparam logic [1:0] TSEL_DIV12 = 2'h0;
  localparam logic [1:0] TSEL_DIV4 = 2'h1;
  // Power and clock control state machine.
  typedef enum logic [1:0] {
    CDRC_RUN = 2'b00,
    CDRC_STOP = 2'b01,
    CDRC_WARM = 2'b11,
    CDRC_HOLD = 2'b10
  } cdrc_state_t;
endpackage

//--- testbench/cdrc_checker.sv
// Port assertions for the clock divide and reset control block.
`timescale 1ns/100ps
module cdrc_checker import cdrc_pkg::*; #(
  parameter int XTAL_WAIT = 16,
  parameter int FAIL_GAP = 8
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic rst_pin_in,
  input wire logic power_fail_rst_in,
  input wire logic power_on_rst_in,
  input wire logic watchdog_rst_in,
  input wire logic system_rst_in,
  input wire logic pmr_wr_in,
  input wire logic [1:0] clock_divide_wr_in,
  input wire logic power_control_reg_wr_in,
  input wire logic [5:0] irq_level_in,
  input wire logic [5:0] irq_allowed_in,
  input wire logic [1:0] tx_active_in,
  input wire logic [1:0] rx_active_in,
  input wire logic [1:0] clock_divide_out,
  input wire logic switchback_enable_out,
  input wire logic osc_fail_detect_enable_out,
  input wire logic osc_fail_flag_out,
  input wire logic ring_mode_status_out,
  input wire logic core_rst_out,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_out
);
  logic int_rst;
  logic quiet;
  logic sb_ev;
  // Any reset or ring clocking overrides a divider write, so such cycles are left out.
  assign int_rst = power_fail_rst_in | watchdog_rst_in | system_rst_in;
  assign quiet = !(int_rst | rst_pin_in | power_on_rst_in | core_rst_out | ring_mode_status_out);
  assign sb_ev = |(((~irq_level_in & 6'h2b) | (irq_level_in & 6'h14)) & irq_allowed_in) | (|tx_active_in);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////
  pin_hold_a: assert property (rst_pin_in |=> core_rst_out)
    else $error("core reset not held by pin");
  pin_drive_a: assert property (int_rst |=> rst_pin_oe_out && rst_pin_out)
    else $error("reset pin not driven");
  pmm_take_a: assert property (pmr_wr_in && clock_divide_wr_in == CDIV_PMM && quiet && !switchback_enable_out
    && !(|{tx_active_in, rx_active_in}) |=> clock_divide_out == CDIV_PMM)
    else $error("slow divider write lost");
  busy_keep_a: assert property (pmr_wr_in && clock_divide_wr_in == CDIV_PMM && |{tx_active_in, rx_active_in}
    |=> clock_divide_out != CDIV_PMM)
    else $error("slow divider taken while serial busy");
  src_div_a: assert property (int_rst || rst_pin_in |=> clock_divide_out == CDIV_ONE)
    else $error("divider not restored by reset");
  sb_back_a: assert property (switchback_enable_out && clock_divide_out == CDIV_PMM && sb_ev
    |=> clock_divide_out == CDIV_ONE)
    else $error("switchback missed");
  no_sb_a: assert property (!switchback_enable_out && clock_divide_out == CDIV_PMM && !pmr_wr_in && quiet
    |=> clock_divide_out == CDIV_PMM)
    else $error("divider moved without switchback");
  ring_lock_a: assert property (ring_mode_status_out |=> clock_divide_out == CDIV_ONE)
    else $error("divider unlocked on ring");
  flag_keep_a: assert property (osc_fail_flag_out && !power_control_reg_wr_in && !power_on_rst_in |=> osc_fail_flag_out)
    else $error("fail flag lost");
  fde_keep_a: assert property (osc_fail_detect_enable_out && !power_control_reg_wr_in && !power_fail_rst_in
    |=> osc_fail_detect_enable_out)
    else $error("fail detect enable lost");
  cover property ($rose(ring_mode_status_out));
  cover property (sb_ev && switchback_enable_out && clock_divide_out == CDIV_PMM);
  cover property ($rose(osc_fail_flag_out));
endmodule
bind cdrc_top cdrc_checker #(.XTAL_WAIT(XTAL_WAIT), .FAIL_GAP(FAIL_GAP)) u_chk (.*);

//--- testbench/cdrc_partner.sv
// Far side model: external reset circuit on the pin and the crystal.
`timescale 1ns/100ps
module cdrc_partner #(
  parameter int XDIV = 2
) (
  input wire logic clk_in,
  input wire logic press_in,
  input wire logic xtal_run_in,
  input wire logic pin_drv_in,
  input wire logic pin_oe_in,
  output logic pin_lvl_out,
  output logic xtal_edge_out = 1'b0
);
  int hold_q = 0;
  int xcnt_q = 0;
  // A press is stretched so the pin never stays high for fewer than three clocks.
  always_ff @(posedge clk_in) begin
    hold_q <= press_in ? 3 : (hold_q > 0 ? hold_q - 1 : 0);
  end
  // The pin is high while either party pulls it up.
  assign pin_lvl_out = (hold_q > 0) | (pin_oe_in & pin_drv_in);
  // A parked crystal gives no pulses at all.
  always_ff @(posedge clk_in) begin
    xcnt_q <= (xcnt_q + 1) % XDIV;
    xtal_edge_out <= xtal_run_in && xcnt_q == 0;
  end
endmodule

//--- testbench/cdrc_top_tb.sv
// Self-checking bench for the clock divide and reset control block.
`timescale 1ns/100ps
module cdrc_top_tb;
  import cdrc_pkg::*;
  logic core_clk_in, rst_n_in, rst_pin_in, xtal_edge_in, press, xrun, stop_req_in, stop_wake_in, pmr_wr_in;
  logic switchback_enable_wr_in, multiplier_select_in, power_control_reg_wr_in, extended_interrupt_flag_reg_wr_in, ring_select_wr_in;
  logic osc_fail_detect_enable_wr_in, osc_fail_flag_wr_in, serial_double_rate_in;
  logic [1:0] clock_divide_wr_in, rx_enable_in, rx_pin_in, tx_active_in, rx_active_in, timer_clock_select_in;
  logic [5:0] irq_level_in, irq_allowed_in;
  logic [3:0] irst;
  logic [1:0] clock_divide_out;
  logic [2:0] mc_ratio_out;
  logic [15:0] pc_load_out;
  logic rst_pin_out, rst_pin_oe_out, switchback_enable_out, osc_fail_detect_enable_out, osc_fail_flag_out;
  logic ring_select_out, ring_mode_status_out, ring_osc_on_out, core_rst_out;
  logic mc_tick_out, timer_tick_out, serial_tick_out, baud_tick_out;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  wire [3:0] ticks = {baud_tick_out, serial_tick_out, timer_tick_out, mc_tick_out};
  // Short crystal wait and fail gap keep the run brief.
  cdrc_top #(.XTAL_WAIT(16), .FAIL_GAP(8)) dut (.*, .power_fail_rst_in(irst[0]), .watchdog_rst_in(irst[1]),
    .system_rst_in(irst[2]), .power_on_rst_in(irst[3]));
  cdrc_partner #(.XDIV(2)) far (.clk_in(core_clk_in), .press_in(press), .xtal_run_in(xrun),
    .pin_drv_in(rst_pin_out), .pin_oe_in(rst_pin_oe_out), .pin_lvl_out(rst_pin_in), .xtal_edge_out(xtal_edge_in));
  ////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_in);
  endtask
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Write strobes last one cycle; the value shows after the edge that takes them.
  task automatic power_management_reg(input logic [1:0] cd, input logic switchback_enable);
    cyc(1);
    pmr_wr_in <= 1'b1;
    clock_divide_wr_in <= cd;
    switchback_enable_wr_in <= switchback_enable;
    cyc(1);
    pmr_wr_in <= 1'b0;
  endtask
  task automatic extended_interrupt_flag_reg(input logic rs);
    cyc(1);
    extended_interrupt_flag_reg_wr_in <= 1'b1;
    ring_select_wr_in <= rs;
    cyc(1);
    extended_interrupt_flag_reg_wr_in <= 1'b0;
  endtask
  // Period between two pulses of one tick output; the first pulse may be a partial period.
  task automatic gap(input int sel, output int n);
    n = 0;
    do cyc(1); while (ticks[sel] !== 1'b1);
    do begin cyc(1); n++; end while (ticks[sel] !== 1'b1);
  endtask
  task automatic t_divide();
    int k;
    power_management_reg(CDIV_PMM, 1'b0);
    #1 chk(clock_divide_out, CDIV_PMM);
    gap(0, k);
    chk(k, 1024);
    chk(mc_ratio_out, 3'h3);
    gap(1, k);
    chk(k, 12288);
    power_management_reg(CDIV_RSVD, 1'b0);
    {irq_level_in, irq_allowed_in, tx_active_in} <= {6'h14, 6'h3f, 2'h3};
    cyc(4);
    #1 chk(clock_divide_out, CDIV_PMM);
    cyc(1);
    {irq_level_in, irq_allowed_in, tx_active_in, multiplier_select_in} <= {6'h2b, 6'h00, 2'h0, 1'b1};
    power_management_reg(CDIV_FAST, 1'b0);
    gap(0, k);
    chk(k, 1);
    chk(mc_ratio_out, 3'h4);
    multiplier_select_in <= 1'b0;
    cyc(2);
    #1 chk(mc_ratio_out, 3'h0);
    power_management_reg(CDIV_ONE, 1'b0);
    gap(1, k);
    chk(k, 12);
    chk(mc_ratio_out, 3'h2);
    gap(2, k);
    chk(k, 64);
    serial_double_rate_in <= 1'b1;
    gap(2, k);
    chk(k, 32);
    gap(3, k);
    chk(k, 2);
    timer_clock_select_in <= 2'h1;
    gap(1, k);
    chk(k, 4);
    timer_clock_select_in <= 2'h2;
    gap(1, k);
    chk(k, 1);
    {multiplier_select_in, rx_active_in} <= {1'b0, 2'h1};
    power_management_reg(CDIV_PMM, 1'b0);
    #1 chk(clock_divide_out, CDIV_ONE);
    cyc(1);
    rx_active_in <= 2'h0;
  endtask
  // A disallowed level is ignored; each qualified event returns the divider to one.
  task automatic t_switch();
    rx_enable_in <= 2'h1;
    power_management_reg(CDIV_PMM, 1'b1);
    irq_level_in <= 6'h00;
    cyc(3);
    #1 chk({switchback_enable_out, clock_divide_out}, 3'h7);
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      {irq_level_in, irq_allowed_in, rx_pin_in, tx_active_in} <= {6'h2b, 6'h00, 2'h3, 2'h0};
      power_management_reg(CDIV_PMM, 1'b1);
      if (i < 6) irq_level_in[i] <= (i == 2 || i == 4);
      {irq_allowed_in, rx_pin_in[0], tx_active_in[1]} <= {6'h3f, i != 6, i == 7};
      cyc(2);
      #1 chk(clock_divide_out, CDIV_ONE);
    end
    cyc(1);
    {irq_allowed_in, tx_active_in} <= {6'h00, 2'h0};
  endtask
  // Stop parks the crystal without a reset, then wakes by interrupt or by the pin.
  task automatic sleep(input logic by_pin);
    cyc(1);
    {stop_req_in, xrun} <= 2'h2;
    cyc(1);
    stop_req_in <= 1'b0;
    cyc(20);
    #1 chk({core_rst_out, osc_fail_flag_out}, 2'h0);
    cyc(1);
    {stop_wake_in, press, xrun} <= {!by_pin, by_pin, 1'b1};
    cyc(1);
    {stop_wake_in, press} <= 2'h0;
  endtask
  task automatic t_osc();
    cyc(1);
    {power_control_reg_wr_in, osc_fail_detect_enable_wr_in} <= 2'h3;
    cyc(1);
    {power_control_reg_wr_in, xrun} <= 2'h0;
    cyc(20);
    #1 chk({core_rst_out, ring_osc_on_out, osc_fail_flag_out, osc_fail_detect_enable_out}, 4'hf);
    cyc(1);
    xrun <= 1'b1;
    cyc(10);
    #1 chk({core_rst_out, osc_fail_flag_out}, 2'h1);
    cyc(1);
    irst[3] <= 1'b1;
    cyc(1);
    irst[3] <= 1'b0;
    cyc(3);
    #1 chk(osc_fail_flag_out, 1'b0);
    extended_interrupt_flag_reg(1'b1);
    #1 chk(ring_select_out, 1'b1);
    sleep(1'b0);
    power_management_reg(CDIV_PMM, 1'b0);
    #1 chk({ring_mode_status_out, ring_osc_on_out, core_rst_out, clock_divide_out}, 5'h1a);
    cyc(40);
    #1 chk({ring_mode_status_out, ring_osc_on_out, clock_divide_out}, 4'h2);
    extended_interrupt_flag_reg(1'b0);
    sleep(1'b0);
    cyc(3);
    #1 chk(core_rst_out, 1'b1);
    cyc(50);
    #1 chk(core_rst_out, 1'b0);
    sleep(1'b1);
    cyc(3);
    #1 chk({core_rst_out, pc_load_out}, 17'h1_0000);
    cyc(50);
    #1 chk(core_rst_out, 1'b0);
  endtask
  // Pin reset from the far side, then each internal source driving the pin outward.
  task automatic t_reset();
    power_management_reg(CDIV_PMM, 1'b0);
    press <= 1'b1;
    cyc(1);
    press <= 1'b0;
    cyc(2);
    #1 chk({core_rst_out, pc_load_out, clock_divide_out}, {1'b1, RESET_VECTOR, CDIV_ONE});
    cyc(3);
    #1 chk(core_rst_out, 1'b0);
    for (int i = 0; i < 3; i++) begin
      cyc(1);
      irst[i] <= 1'b1;
      cyc(3);
      #1 chk({rst_pin_oe_out, rst_pin_out, core_rst_out, clock_divide_out}, 5'h1e);
      cyc(1);
      irst[i] <= 1'b0;
      cyc(8);
      #1 chk({rst_pin_oe_out, core_rst_out}, 2'h0);
    end
    chk(osc_fail_detect_enable_out, 1'b0);
  endtask
  // Free-running system clock.
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // Cycle ceiling cuts a hung run short.
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      stop_test();
    end
  end
  // Quiet inputs, four reset cycles, then the scenarios.
  initial begin
    {rst_n_in, press, stop_req_in, stop_wake_in, pmr_wr_in, switchback_enable_wr_in, multiplier_select_in} = '0;
    {power_control_reg_wr_in, extended_interrupt_flag_reg_wr_in, ring_select_wr_in, osc_fail_detect_enable_wr_in, osc_fail_flag_wr_in} = '0;
    {serial_double_rate_in, clock_divide_wr_in, rx_enable_in, tx_active_in, rx_active_in} = '0;
    {timer_clock_select_in, irq_allowed_in, irst} = '0;
    {xrun, rx_pin_in, irq_level_in} = {1'b1, 2'h3, 6'h2b};
    cyc(4);
    rst_n_in <= 1'b1;
    cyc(1);
    #1 chk(clock_divide_out, CDIV_RESET);
    t_divide();
    t_switch();
    t_osc();
    t_reset();
    stop_test();
  end
endmodule
